// [bench/gate_fets.sv]
// Model of the external transistor gates behind the pins
`timescale 1ns/1ns
module gate_fets (
  // Pin drive
  input  wire logic [5:0] gate_out,
  input  wire logic [5:0] gate_oe,
  // Transistor state
  output logic      [5:0] fet_on
);
  // An undriven gate sits on its pull-down, so it stays off
  assign fet_on = gate_out & gate_oe;
endmodule

// [bench/tb_gate_drive_enable_logic.sv]
// Self-checking bench for the gate drive enable logic
`timescale 1ns/1ns
module tb_gate_drive_enable_logic;
  import gate_drive_pkg::*;
  logic clock = 0, nrst = 0, por_n = 1, en = 0, uvg = 1, uvl = 1, ck_ok = 0;
  logic boot = 0, wr = 0;
  logic [5:0] lreq = '0, lout, loe, lon;
  logic [4:0] hreq = '0, hout, hoe, hmon;
  logic [9:0] addr = '0;
  logic [15:0] wd = '0, rd;
  int errors = 0, checks_done = 0;
  logic [3:0] cases [5] = '{4'h9, 4'h1, 4'hd, 4'hb, 4'h8};
  gate_drive_enable_logic u_gate_drive_enable_logic (.CLOCK(clock), .NRST(nrst),
    .POWER_ON_RESET_N(por_n), .DRIVER_ENABLE(en), .GATE_SUPPLY_UNDERVOLT(uvg),
    .LOGIC_SUPPLY_UNDERVOLT(uvl), .CLOCK_OK(ck_ok), .BOOTSTRAP_LOW(boot),
    .LOW_REQUEST(lreq), .HIGH_REQUEST(hreq), .REG_ADDR(addr), .REG_WRITE(wr),
    .REG_WDATA(wd), .REG_RDATA(rd), .LOW_GATE_OUT(lout), .LOW_GATE_OE(loe),
    .HIGH_GATE_OUT(hout), .HIGH_GATE_OE(hoe), .HIGH_VDS_MON_EN(hmon));
  gate_fets u_gate_fets (.gate_out(lout), .gate_oe(loe), .fet_on(lon));
  // Two-stage sampling must land before we look
  task settle;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task check(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task wreg(logic [15:0] d);
    @(posedge clock);
    addr <= DRIVER_SETUP_ADDR;
    wd <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Each off condition alone must kill all six commands
  task t_gating;
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      {en, uvg, uvl, ck_ok} <= cases[i];
      lreq <= 6'h3f;
      settle();
      check("low", (i == 0) ? 16'h003f : 16'h0000, lout);
      check("fet", (i == 0) ? 16'h003f : 16'h0000, lon);
    end
  endtask
  // Override frees only channels 3 and 6; clock loss shutdown disabled
  task t_setup;
    wreg(16'h0003);
    {en, uvg, uvl, ck_ok} <= 4'h0;
    settle();
    check("ovr", 16'h0024, lout);
    check("rd", 16'h0003, rd);
    @(posedge clock);
    addr <= 10'h1c4;
    settle();
    check("unmapped", 16'h0000, rd);
    wreg(16'h007c);
    settle();
    check("vds", 16'h0000, hmon);
    wreg(16'h0000);
  endtask
  // Weak bootstrap, enable low and power-on reset keep gates off
  task t_safe;
    @(posedge clock);
    {en, uvg, uvl, ck_ok} <= 4'h9;
    hreq <= 5'h1f;
    boot <= 1'b1;
    settle();
    check("boot", 16'h0000, hout);
    check("vds on", 16'h001f, hmon);
    @(posedge clock);
    boot <= 1'b0;
    settle();
    check("hs on", 16'h001f, hout);
    check("hs oe", 16'h001f, hoe);
    @(posedge clock);
    boot <= 1'b0;
    en <= 1'b0;
    settle();
    check("hs en", 16'h0000, hout);
    @(posedge clock);
    en <= 1'b1;
    por_n <= 1'b0;
    settle();
    check("por ls", 16'h0000, lon);
    check("por hs", 16'h0000, hout);
    check("por oe", 16'h0000, loe);
  endtask
  task complete_run;
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_gating();
    t_setup();
    t_safe();
    complete_run();
  end
  // The run needs about 60 cycles; cut a hang well past that
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule

// [verilog/gate_drive_enable_logic.sv]
// Gate command gating and safe-state logic for high and low pre-drivers
// Overview of operation
// - High gates off on reset or enable low
// - Never drive high gate on weak bootstrap
// - High channels usable as low; monitor off
// - Six independent low-side command channels
// - Low gates held off during reset
// - Enable negated forces low commands off
// - Override bit frees channels 3, 6
// - Either undervoltage forces low commands off
// - Missing clock turns off, can disable
// - Command high only when all conditions good
// - Output enable drives pin both ways
`timescale 1ns/1ns
module gate_drive_enable_logic
  import gate_drive_pkg::*;
#(
  parameter int LOW_CH  = NUM_LOW_CH,
  parameter int HIGH_CH = NUM_HIGH_CH
) (
  // Clock and reset
  input  wire logic               CLOCK,
  input  wire logic               NRST,
  // Safe-state inputs
  input  wire logic               POWER_ON_RESET_N,
  input  wire logic               DRIVER_ENABLE,
  input  wire logic               GATE_SUPPLY_UNDERVOLT,
  input  wire logic               LOGIC_SUPPLY_UNDERVOLT,
  input  wire logic               CLOCK_OK,
  input  wire logic               BOOTSTRAP_LOW,
  // Channel requests
  input  wire logic [LOW_CH-1:0]  LOW_REQUEST,
  input  wire logic [HIGH_CH-1:0] HIGH_REQUEST,
  // Register access
  input  wire logic [9:0]         REG_ADDR,
  input  wire logic               REG_WRITE,
  input  wire logic [15:0]        REG_WDATA,
  output logic      [15:0]        REG_RDATA,
  // Gate outputs
  output logic      [LOW_CH-1:0]  LOW_GATE_OUT,
  output logic      [LOW_CH-1:0]  LOW_GATE_OE,
  output logic      [HIGH_CH-1:0] HIGH_GATE_OUT,
  output logic      [HIGH_CH-1:0] HIGH_GATE_OE,
  output logic      [HIGH_CH-1:0] HIGH_VDS_MON_EN
);

  // Registered condition signals, setup register and derived commands
  logic                          drv_en;
  logic                          uv_any;
  logic                          clk_ok;
  logic                          boot_low;
  logic [LOW_CH-1:0]             low_req;
  logic [HIGH_CH-1:0]            high_req;
  logic [DRIVER_SETUP_WIDTH-1:0] driver_setup_reg;
  logic [DRIVER_SETUP_WIDTH-1:0] next_driver_setup_reg;
  logic [15:0]                   next_rdata;
  logic [LOW_CH-1:0]             low_cmd;
  logic [HIGH_CH-1:0]            high_cmd;
  logic [HIGH_CH-1:0]            high_as_low;
  logic                          clk_gate;
  // Next values of the sampled conditions
  logic                          next_drv_en;
  logic                          next_uv_any;
  logic                          next_clk_ok;
  logic                          next_boot_low;
  logic [LOW_CH-1:0]             next_low_req;
  logic [HIGH_CH-1:0]            next_high_req;
  // Next values of the registered pin outputs
  logic [LOW_CH-1:0]             next_low_gate_out;
  logic [LOW_CH-1:0]             next_low_gate_oe;
  logic [HIGH_CH-1:0]            next_high_gate_out;
  logic [HIGH_CH-1:0]            next_high_gate_oe;
  logic [HIGH_CH-1:0]            next_vds_mon_en;

  // Register write and readback
  always_comb begin
    next_driver_setup_reg = driver_setup_reg;
    if (REG_WRITE && REG_ADDR == DRIVER_SETUP_ADDR) begin
      next_driver_setup_reg = REG_WDATA;
    end
    next_rdata = 16'h0000;
    if (REG_ADDR == DRIVER_SETUP_ADDR) begin
      next_rdata = driver_setup_reg;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      driver_setup_reg <= DRIVER_SETUP_RESET;
      REG_RDATA        <= 16'h0000;
    end else begin
      driver_setup_reg <= next_driver_setup_reg;
      REG_RDATA        <= next_rdata;
    end
  end

  // Next sampled conditions; one register stage keeps gating glitch free
  always_comb begin
    next_drv_en   = DRIVER_ENABLE;
    next_uv_any   = GATE_SUPPLY_UNDERVOLT | LOGIC_SUPPLY_UNDERVOLT;
    next_clk_ok   = CLOCK_OK;
    next_boot_low = BOOTSTRAP_LOW;
    next_low_req  = LOW_REQUEST;
    next_high_req = HIGH_REQUEST;
  end

  // Reset picks the off side of every condition, so no gate starts on
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      drv_en   <= 1'b0;
      uv_any   <= 1'b1;
      clk_ok   <= 1'b0;
      boot_low <= 1'b1;
      low_req  <= '0;
      high_req <= '0;
    end else begin
      drv_en   <= next_drv_en;
      uv_any   <= next_uv_any;
      clk_ok   <= next_clk_ok;
      boot_low <= next_boot_low;
      low_req  <= next_low_req;
      high_req <= next_high_req;
    end
  end

  // Clock-loss shutdown can be disabled by software
  assign clk_gate    = clk_ok | driver_setup_reg[FLD_CLKLOSS_DIS];
  assign high_as_low = driver_setup_reg[FLD_HIGH_AS_LOW +: HIGH_CH];

  // Per-channel low command; power-on reset gates it off, reaching the pins at the next clock edge
  genvar i;
  generate
    for (i = 0; i < LOW_CH; i++) begin : g_low
      logic en_ok;
      assign en_ok = drv_en | (OVR_CHANNEL_MASK[i] & driver_setup_reg[FLD_ENABLE_OVR]);
      assign low_cmd[i] = POWER_ON_RESET_N & en_ok & ~uv_any & clk_gate & low_req[i];
    end
    for (i = 0; i < HIGH_CH; i++) begin : g_high
      // In low-side use the undervoltage and clock-loss gating of a low channel also applies
      assign high_cmd[i] = POWER_ON_RESET_N & drv_en & ~boot_low & high_req[i]
                         & (~high_as_low[i] | (~uv_any & clk_gate));
    end
  endgenerate

  // Next pin values; pin driven outside power-on reset so a low command sinks to power ground
  always_comb begin
    next_low_gate_out  = low_cmd;
    next_low_gate_oe   = {LOW_CH{POWER_ON_RESET_N}};
    next_high_gate_out = high_cmd;
    next_high_gate_oe  = {HIGH_CH{POWER_ON_RESET_N}};
    next_vds_mon_en    = ~high_as_low;
  end

  // Output flops; costs one cycle but keeps the pins free of gating glitches
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      LOW_GATE_OUT    <= '0;
      LOW_GATE_OE     <= '0;
      HIGH_GATE_OUT   <= '0;
      HIGH_GATE_OE    <= '0;
      HIGH_VDS_MON_EN <= '0;
    end else begin
      LOW_GATE_OUT    <= next_low_gate_out;
      LOW_GATE_OE     <= next_low_gate_oe;
      HIGH_GATE_OUT   <= next_high_gate_out;
      HIGH_GATE_OE    <= next_high_gate_oe;
      HIGH_VDS_MON_EN <= next_vds_mon_en;
    end
  end

  // Checks; outputs lag their conditions by one edge, hence the past values
  AST_LOW_OFF_NO_ENABLE: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(drv_en) && !$past(driver_setup_reg[FLD_ENABLE_OVR])
    |-> LOW_GATE_OUT == '0)
    else $error("low gate on with enable low");

  AST_LOW_OFF_UV: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(uv_any)
    |-> LOW_GATE_OUT == '0)
    else $error("low gate on during undervoltage");

  AST_HIGH_OFF_ENABLE: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(drv_en) || !$past(POWER_ON_RESET_N)
    |-> HIGH_GATE_OUT == '0)
    else $error("high gate on while disabled");

  AST_HIGH_BOOT: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(boot_low)
    |-> HIGH_GATE_OUT == '0)
    else $error("high gate on with weak bootstrap");

  AST_LOW_RESET: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(POWER_ON_RESET_N)
    |-> LOW_GATE_OUT == '0 && LOW_GATE_OE == '0)
    else $error("low gate active during power-on reset");

  AST_CLK_LOSS: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(clk_ok) && !$past(driver_setup_reg[FLD_CLKLOSS_DIS])
    |-> LOW_GATE_OUT == '0)
    else $error("low gate on with missing clock");

  AST_LOW_ON: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(drv_en) && !$past(uv_any) && $past(clk_ok) && $past(POWER_ON_RESET_N)
    |-> LOW_GATE_OUT == $past(low_req))
    else $error("low gate does not follow request");

  AST_OVR_CH: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(drv_en) && $past(driver_setup_reg[FLD_ENABLE_OVR]) && !$past(uv_any)
    && $past(clk_ok) && $past(POWER_ON_RESET_N)
    |-> LOW_GATE_OUT == ($past(low_req) & OVR_CHANNEL_MASK))
    else $error("override channels wrong");

  // First edge after reset still shows the reset value, so skip it
  AST_VDS_MON: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(NRST)
    |-> HIGH_VDS_MON_EN == ~$past(high_as_low))
    else $error("monitor enabled in low-side use");

  // Channels outside the override pair never escape the enable
  AST_NON_OVR_CH: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(drv_en)
    |-> (LOW_GATE_OUT & ~OVR_CHANNEL_MASK) == '0)
    else $error("non-override channel on with enable low");

  AST_LOW_OE_ON: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(NRST) && $past(POWER_ON_RESET_N)
    |-> LOW_GATE_OE == '1)
    else $error("low pin not driven out of reset");

  AST_HIGH_RESET: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(POWER_ON_RESET_N)
    |-> HIGH_GATE_OUT == '0 && HIGH_GATE_OE == '0)
    else $error("high gate active during power-on reset");

  AST_LOW_REQ_OFF: assert property (@(posedge CLOCK) disable iff (!NRST)
    1'b1
    |-> (LOW_GATE_OUT & ~$past(low_req)) == '0)
    else $error("low gate on without request");

  AST_HIGH_ON: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(NRST) && $past(drv_en) && !$past(boot_low) && $past(POWER_ON_RESET_N)
    && $past(high_as_low) == '0
    |-> HIGH_GATE_OUT == $past(high_req))
    else $error("high gate does not follow request");

  // A high channel in low-side use obeys the low-side off conditions
  AST_HIGH_AS_LOW_UV: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(uv_any)
    |-> (HIGH_GATE_OUT & $past(high_as_low)) == '0)
    else $error("low-side use of high channel on during undervoltage");

  AST_HIGH_AS_LOW_CLK: assert property (@(posedge CLOCK) disable iff (!NRST)
    !$past(clk_gate)
    |-> (HIGH_GATE_OUT & $past(high_as_low)) == '0)
    else $error("low-side use of high channel on with missing clock");

  // Register write lands one edge later; unmapped reads give zero
  AST_SETUP_WRITE: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(NRST) && $past(REG_WRITE) && $past(REG_ADDR) == DRIVER_SETUP_ADDR
    |-> driver_setup_reg == $past(REG_WDATA))
    else $error("setup register write lost");

  AST_RDATA_UNMAPPED: assert property (@(posedge CLOCK) disable iff (!NRST)
    $past(NRST) && $past(REG_ADDR) != DRIVER_SETUP_ADDR
    |-> REG_RDATA == '0)
    else $error("unmapped address reads nonzero");

  // Per-channel independence of the low commands
  genvar j;
  generate
    for (j = 0; j < LOW_CH; j++) begin : g_chk_low
      AST_LOW_CH_IDLE: assert property (@(posedge CLOCK) disable iff (!NRST)
        !$past(low_req[j])
        |-> !LOW_GATE_OUT[j])
        else $error("low channel on without its own request");
    end
  endgenerate
endmodule

// [verilog/gate_drive_pkg.sv]
// Package: constants for the gate drive enable logic
package gate_drive_pkg;
  // Channel counts
  localparam int NUM_LOW_CH  = 6;
  localparam int NUM_HIGH_CH = 5;
  // Driver setup register address and width
  localparam logic [9:0]  DRIVER_SETUP_ADDR  = 10'h1c5;
  localparam int          DRIVER_SETUP_WIDTH = 16;
  localparam logic [15:0] DRIVER_SETUP_RESET = 16'h0000;
  // Field positions in the driver setup register
  localparam int FLD_ENABLE_OVR   = 0;  // Enable override for low channels 3 and 6
  localparam int FLD_CLKLOSS_DIS  = 1;  // Disable clock-loss shutdown
  localparam int FLD_HIGH_AS_LOW  = 2;  // Base of per-channel high-as-low bits (5)
  // Low channels that may bypass the driver enable (zero based: 3 -> 2, 6 -> 5)
  localparam logic [5:0] OVR_CHANNEL_MASK = 6'h24;
endpackage
